/* pkg/flash_seq_pkg.sv */
// Constants and types for the flash erase and protection command sequencer
package flash_seq_pkg;
	// Clock and operation times
	localparam int  CLK_MHZ          = 100;
	localparam int  CHIP_ERASE_MS    = 400;
	localparam int  PROT_ERASE_MS    = 100;
	localparam int  PROT_PROG_US100  = 125;   // 1.25 ms in units of 10 us
	localparam int  CHIP_ERASE_CYC   = CHIP_ERASE_MS * 1000 * CLK_MHZ;
	localparam int  PROT_ERASE_CYC   = PROT_ERASE_MS * 1000 * CLK_MHZ;
	localparam int  PROT_PROG_CYC    = PROT_PROG_US100 * 10 * CLK_MHZ;
	localparam int  TIMER_W          = 26;

	// Unlock aliases and data codes
	localparam logic [15:0] ALIAS_A    = 16'hf555;
	localparam logic [15:0] ALIAS_B    = 16'hfaaa;
	localparam logic [7:0]  CODE_AA    = 8'haa;
	localparam logic [7:0]  CODE_55    = 8'h55;
	localparam logic [7:0]  CODE_ERASE = 8'h80;
	localparam logic [7:0]  CODE_PROG  = 8'ha0;
	localparam logic [7:0]  CODE_CHIP  = 8'h10;
	localparam logic [7:0]  CODE_PROTP = 8'ha5;
	localparam logic [7:0]  CODE_PROTE = 8'h40;
	localparam logic [7:0]  CODE_IDIN  = 8'h90;
	localparam logic [7:0]  CODE_IDOUT = 8'hf0;

	// Protection bit select addresses (seventh cycle)
	localparam logic [15:0] PROT_ADDR0 = 16'h8000;
	localparam logic [15:0] PROT_ADDR1 = 16'h8080;
	localparam logic [15:0] PROT_ADDR2 = 16'h8100;

	// Read values
	localparam logic [16:0] ID_STATUS_ADDR = 17'h0ff7f;
	localparam logic [4:0]  ID_UPPER_ONES  = 5'h1f;
	localparam logic [15:0] PAR_LOCK_WORD  = 16'h9898;
	localparam logic [7:0]  ERASED_BYTE    = 8'hff;

	// Cycle counter
	localparam logic [2:0]  CYC_FIRST  = 3'h0;
	localparam logic [2:0]  CYC_SIXTH  = 3'h5;

	typedef enum logic [1:0] {
		MODE_CPU      = 2'h0,
		MODE_SERIAL   = 2'h1,
		MODE_PARALLEL = 2'h2
	} prog_mode_t;

	typedef enum logic [1:0] {
		OP_CHIP_ERASE = 2'h0,
		OP_PROT_PROG  = 2'h1,
		OP_PROT_ERASE = 2'h2
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_SEQ   = 2'h1,
		ST_BUSY  = 2'h3,
		ST_ERASE = 2'h2
	} seq_state_t;
endpackage

/* hdl/busy_timer.sv */
// Down counter that times one flash operation
`timescale 1ns/1ns
`default_nettype none
module busy_timer (
	// Clock and reset
	input  wire logic                               ref_clk,
	input  wire logic                               arst_n,
	// Control
	input  wire logic                               start,
	input  wire logic [flash_seq_pkg::TIMER_W-1:0]  load,
	output logic                                    done
);
	typedef struct packed {
		logic [flash_seq_pkg::TIMER_W-1:0] count;
		logic                              run;
	} timer_state_t;

	timer_state_t cur;
	timer_state_t next_cur;

	always_comb begin
		next_cur = cur;
		done = cur.run && (cur.count == '0);
		if (start) begin
			next_cur.count = load;
			next_cur.run = 1'b1;
		end else if (done) begin
			next_cur.run = 1'b0;
		end else if (cur.run) begin
			next_cur.count = cur.count - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end
endmodule
`default_nettype wire

/* hdl/array_eraser.sv */
// Walks the array writing the erased value into every byte
`timescale 1ns/1ns
`default_nettype none
module array_eraser (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	// Control
	input  wire logic         start,
	output logic              active,
	// Array write port
	output logic              wr_en,
	output logic [16:0]       wr_addr,
	output logic [7:0]        wr_data
);
	typedef struct packed {
		logic [16:0] addr;
		logic        run;
	} erase_state_t;

	erase_state_t cur;
	erase_state_t next_cur;

	always_comb begin
		next_cur = cur;
		if (start) begin
			next_cur.addr = '0;
			next_cur.run = 1'b1;
		end else if (cur.run) begin
			next_cur.addr = cur.addr + 1'b1;
			if (&cur.addr) begin
				next_cur.run = 1'b0;
			end
		end
	end

	assign active = cur.run;
	assign wr_en = cur.run;
	assign wr_addr = cur.addr;
	assign wr_data = flash_seq_pkg::ERASED_BYTE;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end
endmodule
`default_nettype wire

/* hdl/flash_erase_security_sequencer.sv */
// Command decoder for chip erase, protection bits and identification mode
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// R1 - Chip erase clears whole array, busy about 400 ms after sixth cycle.
// R2 - Erased bytes read back as all ones.
// R3 - Host waits for busy low before new commands or reads, polling it.
// R4 - Three protection bits; each program sequence sets one bit.
// R5 - CPU or serial mode with bit two: cancel CPU page program, reads allowed.
// R6 - Serial mode with any bit set: refuse external write, read, loader.
// R7 - Parallel mode with bits zero and one: no programming, reads give 9898.
// R8 - One of bits zero or one works in parallel mode; set both anyway.
// R9 - Seventh write address selects protection bit zero, one or two.
// R10 - Protection program keeps busy about 1.25 ms after seventh cycle.
// R11 - Protection erase clears all three bits together, never singly.
// R12 - Protection erase keeps busy about 100 ms.
// R13 - Identification entry makes reads return protection status.
// R14 - Status read gives active-low bits in 2..0, ones in 7..3.
// R15 - Identification exit returns to normal array reads.
// R16 - No flash read served while an operation runs.
// R17 - Page writes of 128 bytes; erase by sector or whole array. Only whole-array erase is built here, with no page writes or sector erase.
// R18 - Read is one transfer; write and erase need command sequences.
// R19 - No reset while an operation is executing.
// R20 - Access only while flash power is on and wake-up enabled.
// R21 - Unlock cycles go to two fixed alias addresses.
// R22 - Busy set on final accepted cycle, cleared when operation ends.
module flash_erase_security_sequencer #(
	parameter int CHIP_ERASE_CYCLES = flash_seq_pkg::CHIP_ERASE_CYC,
	parameter int PROT_ERASE_CYCLES = flash_seq_pkg::PROT_ERASE_CYC,
	parameter int PROT_PROG_CYCLES  = flash_seq_pkg::PROT_PROG_CYC
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	// Mode and power
	input  wire logic [1:0]   prog_mode,
	input  wire logic         flash_power_off,
	input  wire logic         flash_wakeup_enable,
	// CPU bus
	input  wire logic         bus_wr,
	input  wire logic         bus_rd,
	input  wire logic [16:0]  bus_addr,
	input  wire logic [7:0]   bus_wdata,
	output logic [15:0]       bus_rdata,
	output logic              rd_valid,
	output logic              rd_refused,
	// Page program request from elsewhere in the block
	input  wire logic         page_prog_req,
	output logic              page_prog_grant,
	output logic              page_prog_cancel,
	// Serial link commands from an external programmer
	input  wire logic         ext_cmd_req,
	output logic              ext_cmd_grant,
	output logic              ext_cmd_refused,
	// Array port
	output logic [16:0]       arr_addr,
	input  wire logic [7:0]   arr_rdata,
	output logic              arr_wr,
	output logic [7:0]        arr_wdata,
	// Status
	output logic              busy,
	output logic              id_mode,
	output logic [2:0]        protect_bits
);
	typedef struct packed {
		flash_seq_pkg::seq_state_t state;
		logic [2:0]                cycle;
		flash_seq_pkg::op_t        op;
		logic [2:0]                prot;
		logic                      id;
		logic [15:0]               rdata;
		logic                      rvalid;
		logic                      rrefused;
	} seq_t;

	seq_t cur;
	seq_t next_cur;

	logic                               timer_start;
	logic [flash_seq_pkg::TIMER_W-1:0]  timer_load;
	logic                               timer_done;
	logic                               erase_start;
	logic                               erase_active;
	logic [16:0]                        erase_addr;
	logic                               powered;
	logic                               par_lock;
	logic                               ser_lock;
	logic [15:0]                        wa;

	busy_timer busy_timer_i (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.start   (timer_start),
		.load    (timer_load),
		.done    (timer_done)
	);

	array_eraser array_eraser_i (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.start   (erase_start),
		.active  (erase_active),
		.wr_en   (arr_wr),
		.wr_addr (erase_addr),
		.wr_data (arr_wdata)
	);

	// Power gating of all accesses
	assign powered = !flash_power_off && flash_wakeup_enable; // R20
	assign wa = bus_addr[15:0];
	// A single one of bits zero or one already locks in parallel mode
	assign par_lock = (prog_mode == flash_seq_pkg::MODE_PARALLEL) && |cur.prot[1:0]; // R7 R8
	assign ser_lock = (prog_mode == flash_seq_pkg::MODE_SERIAL) && |cur.prot; // R6

	always_comb begin
		next_cur = cur;
		timer_start = 1'b0;
		timer_load = '0;
		erase_start = 1'b0;
		next_cur.rvalid = 1'b0;
		next_cur.rrefused = 1'b0;
		case (cur.state)
			flash_seq_pkg::ST_IDLE, flash_seq_pkg::ST_SEQ: begin
				if (bus_wr && powered) begin // R18
					next_cur.state = flash_seq_pkg::ST_IDLE;
					next_cur.cycle = flash_seq_pkg::CYC_FIRST;
					case (cur.cycle)
						3'h0, 3'h3: begin
							if (wa == flash_seq_pkg::ALIAS_A && bus_wdata == flash_seq_pkg::CODE_AA) begin // R21
								next_cur.state = flash_seq_pkg::ST_SEQ;
								next_cur.cycle = cur.cycle + 3'h1;
							end else if (cur.cycle == 3'h0 && bus_wdata == flash_seq_pkg::CODE_IDOUT) begin
								next_cur.id = 1'b0; // R15
							end
						end
						3'h1, 3'h4: begin
							if (wa == flash_seq_pkg::ALIAS_B && bus_wdata == flash_seq_pkg::CODE_55) begin // R21
								next_cur.state = flash_seq_pkg::ST_SEQ;
								next_cur.cycle = cur.cycle + 3'h1;
							end
						end
						3'h2: begin
							if (wa == flash_seq_pkg::ALIAS_A) begin
								case (bus_wdata)
									flash_seq_pkg::CODE_ERASE: begin
										next_cur.state = flash_seq_pkg::ST_SEQ;
										next_cur.cycle = 3'h3;
									end
									flash_seq_pkg::CODE_IDIN: next_cur.id = 1'b1; // R13
									flash_seq_pkg::CODE_IDOUT: next_cur.id = 1'b0; // R15
									default: next_cur.cycle = flash_seq_pkg::CYC_FIRST;
								endcase
							end
						end
						3'h5: begin
							if (wa == flash_seq_pkg::ALIAS_A && bus_wdata == flash_seq_pkg::CODE_CHIP) begin
								next_cur.op = flash_seq_pkg::OP_CHIP_ERASE;
								next_cur.state = flash_seq_pkg::ST_ERASE; // R22
								erase_start = 1'b1; // R1 R2 R17
								timer_start = 1'b1;
								timer_load = CHIP_ERASE_CYCLES[flash_seq_pkg::TIMER_W-1:0]; // R1
							end else if (bus_wdata == flash_seq_pkg::CODE_PROTE) begin
								next_cur.op = flash_seq_pkg::OP_PROT_ERASE;
								next_cur.state = flash_seq_pkg::ST_BUSY; // R22
								timer_start = 1'b1;
								timer_load = PROT_ERASE_CYCLES[flash_seq_pkg::TIMER_W-1:0]; // R12
							end else if (bus_wdata == flash_seq_pkg::CODE_PROTP) begin
								next_cur.state = flash_seq_pkg::ST_SEQ;
								next_cur.cycle = 3'h6;
							end
						end
						3'h6: begin
							// Seventh cycle picks the bit
							if (wa == flash_seq_pkg::PROT_ADDR0 || wa == flash_seq_pkg::PROT_ADDR1
									|| wa == flash_seq_pkg::PROT_ADDR2) begin // R9
								next_cur.op = flash_seq_pkg::OP_PROT_PROG;
								next_cur.state = flash_seq_pkg::ST_BUSY; // R22
								timer_start = 1'b1;
								timer_load = PROT_PROG_CYCLES[flash_seq_pkg::TIMER_W-1:0]; // R10
								if (wa == flash_seq_pkg::PROT_ADDR0) begin
									next_cur.prot[0] = 1'b1; // R4
								end else if (wa == flash_seq_pkg::PROT_ADDR1) begin
									next_cur.prot[1] = 1'b1; // R4
								end else begin
									next_cur.prot[2] = 1'b1; // R4
								end
							end
						end
						default: next_cur.cycle = flash_seq_pkg::CYC_FIRST;
					endcase
				end
				if (bus_rd) begin
					next_cur.rvalid = powered;
					next_cur.rrefused = !powered;
					if (cur.id && bus_addr == flash_seq_pkg::ID_STATUS_ADDR) begin
						next_cur.rdata = {8'h00, flash_seq_pkg::ID_UPPER_ONES, ~cur.prot}; // R14
					end else if (par_lock) begin
						next_cur.rdata = flash_seq_pkg::PAR_LOCK_WORD; // R7
					end else begin
						next_cur.rdata = {8'h00, arr_rdata};
					end
				end
			end
			flash_seq_pkg::ST_ERASE, flash_seq_pkg::ST_BUSY: begin
				// Array is unreadable until the operation finishes
				if (bus_rd) begin
					next_cur.rrefused = 1'b1; // R16
				end
				if (timer_done) begin
					// For chip erase, busy clears only after both time and array walk are over
					if (cur.state == flash_seq_pkg::ST_ERASE && erase_active) begin
						// Timer pulse is gone next cycle, so mark it for the walk end
						next_cur.state = flash_seq_pkg::ST_ERASE;
						next_cur.cycle = flash_seq_pkg::CYC_SIXTH; // R1 R22
					end else begin
						next_cur.state = flash_seq_pkg::ST_IDLE; // R22
						next_cur.cycle = flash_seq_pkg::CYC_FIRST;
					end
					if (cur.op == flash_seq_pkg::OP_PROT_ERASE) begin
						next_cur.prot = 3'h0; // R11
					end
				end else if (cur.state == flash_seq_pkg::ST_ERASE && !erase_active
						&& cur.cycle == flash_seq_pkg::CYC_SIXTH) begin
					next_cur.state = flash_seq_pkg::ST_IDLE;
					next_cur.cycle = flash_seq_pkg::CYC_FIRST;
				end
			end
			default: next_cur.state = flash_seq_pkg::ST_IDLE;
		endcase
	end

	assign busy = (cur.state == flash_seq_pkg::ST_BUSY)
		|| (cur.state == flash_seq_pkg::ST_ERASE); // R22
	assign id_mode = cur.id;
	assign protect_bits = cur.prot;
	assign bus_rdata = cur.rdata;
	assign rd_valid = cur.rvalid;
	assign rd_refused = cur.rrefused;
	assign arr_addr = erase_active ? erase_addr : bus_addr;
	// Page program gating
	assign page_prog_cancel = page_prog_req && (busy || par_lock
		|| ((prog_mode != flash_seq_pkg::MODE_PARALLEL) && cur.prot[2])); // R5 R7
	assign page_prog_grant = page_prog_req && !page_prog_cancel && powered;
	assign ext_cmd_refused = ext_cmd_req && (ser_lock || busy); // R6
	assign ext_cmd_grant = ext_cmd_req && !ext_cmd_refused && powered;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end
endmodule
`default_nettype wire

/* tb/flash_array_model.sv */
// Byte array model behind the sequencer's array port
`timescale 1ns/1ns
`default_nettype none
module flash_array_model (
	// Clock
	input  wire logic        ref_clk,
	// Array port
	input  wire logic [16:0] arr_addr,
	output logic [7:0]       arr_rdata,
	input  wire logic        arr_wr,
	input  wire logic [7:0]  arr_wdata
);
	logic [7:0] mem [0:131071];
	// All ones at start only where the address low byte is a5, so a missed erase shows
	initial for (int i = 0; i < 131072; i++) mem[i] = i[7:0] ^ 8'h5a;
	always @(posedge ref_clk) if (arr_wr) mem[arr_addr] <= arr_wdata;
	assign arr_rdata = mem[arr_addr];
endmodule
`default_nettype wire

/* tb/seq_chk.sv */
// Port assertions for the flash sequencer
`timescale 1ns/1ns
`default_nettype none
module seq_chk (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        arst_n,
	// Mode, power and bus
	input wire logic [1:0]  prog_mode,
	input wire logic        flash_power_off,
	input wire logic        flash_wakeup_enable,
	input wire logic        bus_rd,
	input wire logic [16:0] bus_addr,
	input wire logic [15:0] bus_rdata,
	input wire logic        rd_valid,
	input wire logic        rd_refused,
	// Side requests
	input wire logic        page_prog_req,
	input wire logic        page_prog_cancel,
	input wire logic        ext_cmd_req,
	input wire logic        ext_cmd_refused,
	// Array and status
	input wire logic        arr_wr,
	input wire logic [7:0]  arr_wdata,
	input wire logic        busy,
	input wire logic        id_mode,
	input wire logic [2:0]  protect_bits
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence rd_ok_s;
		bus_rd && !busy && !flash_power_off && flash_wakeup_enable;
	endsequence
	sequence rd_lock_s;
		rd_ok_s ##0 (prog_mode == 2'h2 && protect_bits[1:0] != 2'h0 && !id_mode);
	endsequence
	busy_refuse_a: assert property (
		bus_rd && busy |=> rd_refused && !rd_valid) else $error("read served while busy");
	power_refuse_a: assert property (
		bus_rd && flash_power_off |=> rd_refused) else $error("read served unpowered");
	par_lock_a: assert property (
		rd_lock_s |=> rd_valid && bus_rdata == 16'h9898) else $error("lock pattern missing");
	id_status_a: assert property (
		rd_ok_s ##0 (id_mode && bus_addr == 17'h0ff7f && prog_mode != 2'h2)
		|=> rd_valid && bus_rdata == {8'h00, 5'h1f, ~protect_bits})
		else $error("status read wrong");
	cancel_prog_a: assert property (
		page_prog_req && protect_bits[2] && prog_mode != 2'h2 |-> page_prog_cancel)
		else $error("page program not cancelled");
	ext_refuse_a: assert property (
		ext_cmd_req && prog_mode == 2'h1 && protect_bits != 3'h0 |-> ext_cmd_refused)
		else $error("serial command not refused");
	one_bit_a: assert property (
		protect_bits != $past(protect_bits) && protect_bits != 3'h0
		|-> $countones(protect_bits ^ $past(protect_bits)) == 1
		&& (protect_bits & $past(protect_bits)) == $past(protect_bits))
		else $error("protection changed by more than one bit");
	all_clear_a: assert property (
		(protect_bits & ~$past(protect_bits)) == 3'h0 && protect_bits != $past(protect_bits)
		|-> protect_bits == 3'h0) else $error("protection cleared partly");
	erase_fill_a: assert property (
		arr_wr |-> arr_wdata == 8'hff && busy) else $error("erase write wrong");
	busy_hold_a: assert property (
		$rose(busy) |-> busy[*8]) else $error("busy dropped early");
endmodule
`default_nettype wire

/* tb/flash_erase_security_sequencer_bench.sv */
// Directed bench for the flash sequencer
`timescale 1ns/1ns
`default_nettype none
module flash_erase_security_sequencer_bench;
	// Short counts keep the run small
	localparam int PP = 20;
	localparam int PE = 30;
	localparam int CE = 100;
	// Eraser walks every byte, so busy outlasts a short timer
	localparam int WALK = 131072;
	logic        ref_clk, arst_n, flash_power_off, flash_wakeup_enable;
	logic        bus_wr, bus_rd, page_prog_req, ext_cmd_req;
	logic [1:0]  prog_mode;
	logic [16:0] bus_addr, arr_addr;
	logic [7:0]  bus_wdata, arr_rdata, arr_wdata;
	logic [15:0] bus_rdata;
	logic        rd_valid, rd_refused, page_prog_grant, page_prog_cancel;
	logic        ext_cmd_grant, ext_cmd_refused, arr_wr, busy, id_mode;
	logic [2:0]  protect_bits;
	logic [15:0] sel [3] = '{16'h8000, 16'h8080, 16'h8100};
	int          failures = 0;
	int          tests_run = 0;
	int          cycles = 0;
	flash_erase_security_sequencer #(
		.CHIP_ERASE_CYCLES(CE), .PROT_ERASE_CYCLES(PE), .PROT_PROG_CYCLES(PP)
	) flash_erase_security_sequencer_i (
		.ref_clk, .arst_n, .prog_mode, .flash_power_off, .flash_wakeup_enable,
		.bus_wr, .bus_rd, .bus_addr, .bus_wdata, .bus_rdata, .rd_valid, .rd_refused,
		.page_prog_req, .page_prog_grant, .page_prog_cancel,
		.ext_cmd_req, .ext_cmd_grant, .ext_cmd_refused,
		.arr_addr, .arr_rdata, .arr_wr, .arr_wdata, .busy, .id_mode, .protect_bits
	);
	flash_array_model flash_array_model_i (.ref_clk, .arr_addr, .arr_rdata, .arr_wr, .arr_wdata);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic conclude;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 200000) begin
			failures++;
			conclude();
		end
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		bus_wr = 1'b1;
		bus_addr = {1'b0, a};
		bus_wdata = d;
		@(negedge ref_clk);
		bus_wr = 1'b0;
	endtask
	task automatic unlock(input logic [7:0] c);
		wr(flash_seq_pkg::ALIAS_A, flash_seq_pkg::CODE_AA);
		wr(flash_seq_pkg::ALIAS_B, flash_seq_pkg::CODE_55);
		wr(flash_seq_pkg::ALIAS_A, c);
	endtask
	task automatic prep(input logic [7:0] c);
		unlock(flash_seq_pkg::CODE_ERASE);
		unlock(c);
	endtask
	task automatic rd(input logic [16:0] a, input logic r, input logic [15:0] e);
		@(negedge ref_clk);
		bus_rd = 1'b1;
		bus_addr = a;
		@(negedge ref_clk);
		chk("rd_refused", {15'h0, r}, {15'h0, rd_refused});
		chk("rd_valid", {15'h0, !r}, {15'h0, rd_valid});
		if (!r)
			chk("bus_rdata", e, bus_rdata);
		bus_rd = 1'b0;
	endtask
	task automatic busy_len(input int n);
		int c;
		c = 0;
		while (busy !== 1'b1 && c < 4) begin
			@(negedge ref_clk);
			c++;
		end
		c = 0;
		while (busy === 1'b1 && c < n + 8) begin
			@(negedge ref_clk);
			c++;
		end
		chk("busy length", 16'h1, {15'h0, c >= n - 3 && c <= n + 3});
	endtask
	initial begin
		{bus_wr, bus_rd, page_prog_req, ext_cmd_req, flash_power_off} = '0;
		flash_wakeup_enable = 1'b1;
		prog_mode = 2'h0;
		bus_addr = '0;
		bus_wdata = '0;
		arst_n = 1'b0;
		repeat (4) @(negedge ref_clk);
		arst_n = 1'b1;
		chk("protect_bits", 16'h0, {13'h0, protect_bits});
		for (int b = 0; b < 3; b++) begin
			prep(flash_seq_pkg::CODE_PROTP);
			wr(sel[b], 8'h00);
			busy_len(PP);
			chk("protect_bits", 16'((2 << b) - 1), {13'h0, protect_bits});
		end
		page_prog_req = 1'b1;
		ext_cmd_req = 1'b1;
		prog_mode = 2'h1;
		@(negedge ref_clk);
		chk("page_prog_cancel", 16'h1, {15'h0, page_prog_cancel});
		chk("ext_cmd_refused", 16'h1, {15'h0, ext_cmd_refused});
		chk("page_prog_grant", 16'h0, {15'h0, page_prog_grant});
		chk("ext_cmd_grant", 16'h0, {15'h0, ext_cmd_grant});
		page_prog_req = 1'b0;
		ext_cmd_req = 1'b0;
		prog_mode = 2'h2;
		rd(17'h00005, 1'b0, 16'h9898);
		prog_mode = 2'h0;
		rd(17'h00005, 1'b0, 16'h005f);
		unlock(flash_seq_pkg::CODE_IDIN);
		chk("id_mode", 16'h1, {15'h0, id_mode});
		rd(17'h0ff7f, 1'b0, 16'h00f8);
		unlock(flash_seq_pkg::CODE_IDOUT);
		chk("id_mode", 16'h0, {15'h0, id_mode});
		rd(17'h00005, 1'b0, 16'h005f);
		unlock(flash_seq_pkg::CODE_IDIN);
		wr(flash_seq_pkg::ALIAS_A, flash_seq_pkg::CODE_IDOUT);
		chk("id_mode", 16'h0, {15'h0, id_mode});
		flash_power_off = 1'b1;
		rd(17'h00005, 1'b1, 16'h0);
		flash_power_off = 1'b0;
		prep(flash_seq_pkg::CODE_PROTE);
		rd(17'h00005, 1'b1, 16'h0);
		busy_len(PE - 2);
		chk("protect_bits", 16'h0, {13'h0, protect_bits});
		page_prog_req = 1'b1;
		ext_cmd_req = 1'b1;
		prog_mode = 2'h1;
		@(negedge ref_clk);
		chk("page_prog_grant", 16'h1, {15'h0, page_prog_grant});
		chk("ext_cmd_grant", 16'h1, {15'h0, ext_cmd_grant});
		page_prog_req = 1'b0;
		ext_cmd_req = 1'b0;
		prog_mode = 2'h0;
		prep(flash_seq_pkg::CODE_CHIP);
		busy_len(WALK);
		rd(17'h00005, 1'b0, 16'h00ff);
		rd(17'h1ffff, 1'b0, 16'h00ff);
		conclude();
	end
endmodule
bind flash_erase_security_sequencer seq_chk seq_chk_i (
	.ref_clk, .arst_n, .prog_mode, .flash_power_off, .flash_wakeup_enable,
	.bus_rd, .bus_addr, .bus_rdata, .rd_valid, .rd_refused,
	.page_prog_req, .page_prog_cancel, .ext_cmd_req, .ext_cmd_refused,
	.arr_wr, .arr_wdata, .busy, .id_mode, .protect_bits
);
`default_nettype wire
